// ===== core/spsel_pkg.sv
// Purpose: Constants for the status output pin select block
// Assumes: APB register map with 32-bit aligned words
// Notes: Offsets are byte addresses
package spsel_pkg;
    // Register byte offsets
    localparam logic [11:0] SPSEL_CFG_OFS = 12'h000;
    localparam logic [11:0] SPSEL_STS_OFS = 12'h004;
    // Configuration field positions
    localparam int SPSEL_SEL_LSB = 0;
    localparam int SPSEL_POL_BIT = 8;
    localparam int SPSEL_PU_BIT = 9;
    localparam int SPSEL_PD_BIT = 10;
    localparam int SPSEL_HIZ_BIT = 11;
    localparam int SPSEL_OD_BIT = 12;
    // Writable bit mask and reset value of the configuration register
    localparam logic [15:0] SPSEL_CFG_MASK = 16'h1F1F;
    localparam logic [15:0] SPSEL_CFG_RST = 16'h0200;
    // Status register bit position
    localparam int SPSEL_STS_PIN_BIT = 1;
    // Selector codes
    localparam logic [4:0] SPSEL_APLL = 5'h00;
    localparam logic [4:0] SPSEL_DPLL = 5'h01;
    localparam logic [4:0] SPSEL_LOS0 = 5'h02;
    localparam logic [4:0] SPSEL_LOS1 = 5'h03;
    localparam logic [4:0] SPSEL_LOSX = 5'h04;
    localparam logic [4:0] SPSEL_ACT0 = 5'h05;
    localparam logic [4:0] SPSEL_ACT1 = 5'h06;
    localparam logic [4:0] SPSEL_INV0 = 5'h07;
    localparam logic [4:0] SPSEL_INV1 = 5'h08;
    localparam logic [4:0] SPSEL_IRQ = 5'h09;
    localparam logic [4:0] SPSEL_RDY = 5'h0A;
    localparam logic [4:0] SPSEL_LOW = 5'h1D;
    localparam logic [4:0] SPSEL_HIGH = 5'h1E;
    localparam logic [4:0] SPSEL_RAW = 5'h1F;
endpackage

// ===== core/spsel_top.sv
// Purpose: Status output pin selector with polarity, open-drain and pad controls
// Assumes: Indicators arrive asynchronously; APB slave always ready, no wait states
// Notes: Pin is split into output, output enable and pad pull controls
//
// Operation
// - Five-bit selector picks loop settled or signal-loss flags for codes 0x0 to 0x4.
// - Codes 0x5-0x6 give activity status, 0x7-0x8 invalid-reference status.
// - Code 0x9 outputs OR of interrupt status ANDed with enable.
// - 0xA is device ready, 0x1D low, 0x1E high, others reserved.
// - Polarity bit clear passes indicator, set inverts it.
// - With selector 0x1F polarity has no effect on the pin.
// - Open-drain drives low while the level is low, otherwise releases the pin.
// - Tristate bit disables the output driver entirely.
// - Pull-down bit enables internal pull-down on the pin.
// - Pull-up bit enables weak internal pull-up and resets to one.
// - Status bit mirrors the level after polarity for selector 0x0-0x4 in every drive mode, else zero.
`timescale 1ns/1ps
module spsel_top
    import spsel_pkg::*;
#(
    parameter int IRQ_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Indicators from the device
    input wire logic apll_settled,
    input wire logic dpll_settled,
    input wire logic loss_monitor_ref0,
    input wire logic loss_monitor_ref1,
    input wire logic loss_monitor_xtal,
    input wire logic activity_monitor_ref0,
    input wire logic activity_monitor_ref1,
    input wire logic ref0_invalid,
    input wire logic ref1_invalid,
    input wire logic [IRQ_W-1:0] irq_status,
    input wire logic [IRQ_W-1:0] irq_enable,
    input wire logic device_ready,
    // Status pin and pad controls
    output logic status_pin_o,
    output logic status_pin_oe,
    output logic pin_pullup_en,
    output logic pin_pulldown_en
);

    // Indicator count after flattening, and their positions
    localparam int NIND = 10 + 2 * IRQ_W;
    localparam int IX_APLL = 0;
    localparam int IX_DPLL = 1;
    localparam int IX_LOS0 = 2;
    localparam int IX_LOS1 = 3;
    localparam int IX_LOSX = 4;
    localparam int IX_ACT0 = 5;
    localparam int IX_ACT1 = 6;
    localparam int IX_INV0 = 7;
    localparam int IX_INV1 = 8;
    localparam int IX_RDY = 9;
    localparam int IX_IRQ_ST = 10;
    localparam int IX_IRQ_EN = 10 + IRQ_W;

    // Synchroniser stages for all indicators
    logic [NIND-1:0] ind_raw;
    logic [NIND-1:0] sync1_q;
    logic [NIND-1:0] sync2_q;

    // Configuration fields, each in its own flip-flops
    logic [4:0] sel_q;
    logic pol_q;
    logic pu_q;
    logic pd_q;
    logic hiz_q;
    logic od_q;
    logic [15:0] cfg_view;
    logic [31:0] sts_view;

    // Synchronised indicators
    logic apll_s;
    logic dpll_s;
    logic los0_s;
    logic los1_s;
    logic losx_s;
    logic act0_s;
    logic act1_s;
    logic inv0_s;
    logic inv1_s;
    logic rdy_s;
    logic [IRQ_W-1:0] irq_st_s;
    logic [IRQ_W-1:0] irq_en_s;

    // Selection and drive path
    logic ind;
    logic level;
    logic out_d;
    logic oe_d;
    logic out_q;
    logic oe_q;
    logic mirror_d;
    logic mirror_q;

    // Bus decode and read path
    logic wr_cfg;
    logic rd_setup;
    logic [31:0] rdata_d;

    // True when a bus address hits a register offset
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
        return addr == ofs;
    endfunction

    // Polarity applied to an indicator; the raw code ignores it
    function automatic logic apply_pol(input logic i, input logic p, input logic [4:0] s);
        return (p && s != SPSEL_RAW) ? ~i : i;
    endfunction

    // Open-drain pulls low while the output value is low, else releases
    function automatic logic od_drive(input logic lvl);
        return ~lvl;
    endfunction

    // Codes whose output value is mirrored into the status register
    function automatic logic mirrored(input logic [4:0] s);
        return s <= SPSEL_LOSX;
    endfunction

    // Flatten the asynchronous indicators into one vector
    assign ind_raw = {irq_enable, irq_status, device_ready, ref1_invalid, ref0_invalid,
                      activity_monitor_ref1, activity_monitor_ref0, loss_monitor_xtal,
                      loss_monitor_ref1, loss_monitor_ref0, dpll_settled, apll_settled};

    // First synchroniser stage; nothing but the second stage reads it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
        end else begin
            sync1_q <= ind_raw;
        end
    end

    // Second synchroniser stage, the only source for logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync2_q <= '0;
        end else begin
            sync2_q <= sync1_q;
        end
    end

    // Unpack the synchronised indicators
    assign apll_s = sync2_q[IX_APLL];
    assign dpll_s = sync2_q[IX_DPLL];
    assign los0_s = sync2_q[IX_LOS0];
    assign los1_s = sync2_q[IX_LOS1];
    assign losx_s = sync2_q[IX_LOSX];
    assign act0_s = sync2_q[IX_ACT0];
    assign act1_s = sync2_q[IX_ACT1];
    assign inv0_s = sync2_q[IX_INV0];
    assign inv1_s = sync2_q[IX_INV1];
    assign rdy_s = sync2_q[IX_RDY];
    assign irq_st_s = sync2_q[IX_IRQ_ST +: IRQ_W];
    assign irq_en_s = sync2_q[IX_IRQ_EN +: IRQ_W];

    // APB strobes; the access phase is a single cycle
    assign wr_cfg = psel && penable && pwrite && addr_hit(paddr, SPSEL_CFG_OFS);
    assign rd_setup = psel && !penable && !pwrite;

    // Always ready, never an error
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Selector field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= SPSEL_CFG_RST[SPSEL_SEL_LSB +: 5];
        end else if (wr_cfg) begin
            sel_q <= pwdata[SPSEL_SEL_LSB +: 5];
        end
    end

    // Polarity field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_q <= SPSEL_CFG_RST[SPSEL_POL_BIT];
        end else if (wr_cfg) begin
            pol_q <= pwdata[SPSEL_POL_BIT];
        end
    end

    // Pull-up field, set after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pu_q <= SPSEL_CFG_RST[SPSEL_PU_BIT];
        end else if (wr_cfg) begin
            pu_q <= pwdata[SPSEL_PU_BIT];
        end
    end

    // Pull-down field; software keeps it off in open-drain mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_q <= SPSEL_CFG_RST[SPSEL_PD_BIT];
        end else if (wr_cfg) begin
            pd_q <= pwdata[SPSEL_PD_BIT];
        end
    end

    // Tristate field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hiz_q <= SPSEL_CFG_RST[SPSEL_HIZ_BIT];
        end else if (wr_cfg) begin
            hiz_q <= pwdata[SPSEL_HIZ_BIT];
        end
    end

    // Open-drain field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            od_q <= SPSEL_CFG_RST[SPSEL_OD_BIT];
        end else if (wr_cfg) begin
            od_q <= pwdata[SPSEL_OD_BIT];
        end
    end

    // Register view; reserved bits are not stored and read zero
    always_comb begin
        cfg_view = '0;
        cfg_view[SPSEL_SEL_LSB +: 5] = sel_q;
        cfg_view[SPSEL_POL_BIT] = pol_q;
        cfg_view[SPSEL_PU_BIT] = pu_q;
        cfg_view[SPSEL_PD_BIT] = pd_q;
        cfg_view[SPSEL_HIZ_BIT] = hiz_q;
        cfg_view[SPSEL_OD_BIT] = od_q;
    end

    // Status view; only the pin mirror bit is used
    always_comb begin
        sts_view = '0;
        sts_view[SPSEL_STS_PIN_BIT] = mirror_q;
    end

    // Indicator selection
    always_comb begin
        case (sel_q)
            SPSEL_APLL: ind = apll_s;
            SPSEL_DPLL: ind = dpll_s;
            SPSEL_LOS0: ind = los0_s;
            SPSEL_LOS1: ind = los1_s;
            SPSEL_LOSX: ind = losx_s;
            SPSEL_ACT0: ind = act0_s;
            SPSEL_ACT1: ind = act1_s;
            SPSEL_INV0: ind = inv0_s;
            SPSEL_INV1: ind = inv1_s;
            SPSEL_IRQ: ind = |(irq_st_s & irq_en_s);
            SPSEL_RDY: ind = rdy_s;
            SPSEL_LOW: ind = 1'b0;
            SPSEL_HIGH: ind = 1'b1;
            default: ind = 1'b0; // Reserved codes output low
        endcase
    end

    // Polarity, ignored for selector 0x1F
    assign level = apply_pol(ind, pol_q, sel_q);

    // Drive mode: tristate over open-drain over push-pull
    always_comb begin
        if (hiz_q) begin
            out_d = 1'b0;
            oe_d = 1'b0;
        end else if (od_q) begin
            out_d = 1'b0;
            oe_d = od_drive(level);
        end else begin
            out_d = level;
            oe_d = 1'b1;
        end
    end

    // Status mirror value
    assign mirror_d = mirrored(sel_q) ? level : 1'b0;

    // Registered pin value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    // Registered drive enable, released during reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_d;
        end
    end

    // Registered status mirror, same timing as the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mirror_q <= 1'b0;
        end else begin
            mirror_q <= mirror_d;
        end
    end

    // Pin and pad outputs
    assign status_pin_o = out_q;
    assign status_pin_oe = oe_q;
    assign pin_pullup_en = pu_q;
    assign pin_pulldown_en = pd_q;

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        if (addr_hit(paddr, SPSEL_CFG_OFS)) begin
            rdata_d = {16'h0000, cfg_view};
        end else if (addr_hit(paddr, SPSEL_STS_OFS)) begin
            rdata_d = sts_view;
        end else begin
            rdata_d = '0;
        end
    end

    // Read data, loaded in the setup cycle of a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= rdata_d;
        end
    end

endmodule

// ===== sim/spsel_asserts.sv
// Purpose: Port checks for status pin select
// Assumes: Zero-wait APB, config at 0x000
// Notes: Pin moves two edges after a write
`timescale 1ns/1ps
module spsel_asserts (
    // APB side
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Pin side
    input wire logic status_pin_o, status_pin_oe, pin_pullup_en, pin_pulldown_en
);
    // Config write decode and plain push-pull drive
    wire wc = psel && penable && pwrite && paddr == 12'h000;
    wire pp = wc && !pwdata[11] && !pwdata[12];
    wire [4:0] s = pwdata[4:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pullup_follow: assert property (
        wc |=> pin_pullup_en == $past(pwdata[9])) else $error("pull-up off");
    a_pulldown_follow: assert property (
        wc |=> pin_pulldown_en == $past(pwdata[10])) else $error("pull-down off");
    a_hiz_release: assert property (
        wc && pwdata[11] |-> ##2 !status_pin_oe) else $error("pin driven");
    a_od_low_only: assert property (
        wc && pwdata[12] |-> ##2 !status_pin_o) else $error("od drives high");
    a_const_high: assert property (
        pp && s == 5'h1E && !pwdata[8] |-> ##2 status_pin_o && status_pin_oe) else $error("not high");
    a_const_low_inv: assert property (
        pp && s == 5'h1D && pwdata[8] |-> ##2 status_pin_o) else $error("not inverted");
    a_raw_no_pol: assert property (
        pp && s == 5'h1F |-> ##2 !status_pin_o) else $error("polarity used");
    a_cfg_rsvd_zero: assert property (
        psel && !pwrite && paddr == 12'h000 |=> prdata[31:13] == '0 && prdata[7:5] == '0)
        else $error("reserved set");
    // Main scenarios
    c_od: cover property (wc && pwdata[12]);
    c_irq: cover property (wc && s == 5'h09);
    c_high: cover property (status_pin_o && status_pin_oe);
endmodule
bind spsel_top spsel_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .status_pin_o, .status_pin_oe, .pin_pullup_en, .pin_pulldown_en);

// ===== sim/spsel_board.sv
// Purpose: Board logic reading the status pin
// Assumes: No external pull on the net
// Notes: A floating net toggles each cycle
`timescale 1ns/1ps
module spsel_board (
    // Pad drive and pulls
    input wire logic pclk, o, oe, pu, pd,
    // Net level
    output logic lvl
);
    initial lvl = 1'b0;
    // Driver wins, then pulls, else the net drifts
    always @(posedge pclk) lvl <= oe ? o : pu ? 1'b1 : pd ? 1'b0 : ~lvl;
endmodule

// ===== sim/status_output_pin_select_tb.sv
// Purpose: Self-checking bench for status pin select
// Assumes: Pin settles within four edges
// Notes: Seeded random indicators
`timescale 1ns/1ps
module status_output_pin_select_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, o, oe, pu, pd, lvl;
    logic [11:0] paddr = '0;
    logic slverr;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [9:0] fl = '0;
    logic [7:0] irs = '0, ire = '0;
    int miscompares = 0, n_tests = 0, cyc = 0;
    // Clock, timeout and instances
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 5000) begin
        miscompares++;
        finish_test();
    end
    spsel_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr(slverr), .apll_settled(fl[0]), .dpll_settled(fl[1]), .loss_monitor_ref0(fl[2]),
        .loss_monitor_ref1(fl[3]), .loss_monitor_xtal(fl[4]), .activity_monitor_ref0(fl[5]),
        .activity_monitor_ref1(fl[6]), .ref0_invalid(fl[7]), .ref1_invalid(fl[8]),
        .irq_status(irs), .irq_enable(ire), .device_ready(fl[9]), .status_pin_o(o),
        .status_pin_oe(oe), .pin_pullup_en(pu), .pin_pulldown_en(pd));
    spsel_board u_brd (.pclk, .o, .oe, .pu, .pd, .lvl);
    // Expected pin level for a selector and polarity
    function automatic logic exp_lvl(input logic [4:0] s, input logic p);
        logic i;
        i = s < 5'h09 ? fl[s] : s == 5'h09 ? |(irs & ire) : s == 5'h0A ? fl[9] : s == 5'h1E;
        return i ^ (p && s != 5'h1F);
    endfunction
    // Compare and count
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, read data lands in rd
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'h0;
        @(posedge pclk);
    endtask
    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Registers, then every selector code under both polarities
    initial begin
        void'($urandom(47003));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk(pu, 1'b1);
        apb(1'b0, 12'h000, '0);
        chk(rd, 32'h0200);
        apb(1'b1, 12'h000, '1);
        apb(1'b0, 12'h000, '0);
        chk(rd, 32'h1F1F);
        chk(pd, 1'b1);
        chk({oe, lvl}, 2'h1);
        apb(1'b0, 12'h008, '0);
        chk(rd, '0);
        chk(slverr, 1'b0);
        $display("Test registers done");
        for (int k = 0; k < 64; k++) begin
            fl <= 10'($urandom);
            irs <= k == 9 ? 8'hFF : 8'($urandom);
            ire <= k == 9 ? 8'h00 : 8'($urandom);
            apb(1'b1, 12'h000, {19'h0, k[4:0] < 5'h0B && k[0], 3'h1, k[5], 3'h0, k[4:0]});
            repeat (4) @(posedge pclk);
            if (k[4:0] < 5'h0B || k[4:0] > 5'h1C)
                chk(lvl, exp_lvl(k[4:0], k[5]));
            apb(1'b0, 12'h004, '0);
            chk(rd, {k[4:0] < 5'h05 && exp_lvl(k[4:0], k[5]), 1'b0});
        end
        $display("Test selector sweep done");
        finish_test();
    end
endmodule
